// ### ies_pkg.sv
package ies_pkg;
    localparam int IES_N_NODE = 112;
    localparam int IES_NODE_W = 7;
    localparam int IES_PRIO_W = 4;
    localparam int IES_N_SHARED = 8;
    localparam int IES_SHARED_FIRST = 104;
    localparam int IES_N_SHSRC = 16;
    localparam int IES_SEL_W = 4;
    localparam int IES_N_PEC = 8;
    localparam int IES_PEC_W = 3;
    localparam int IES_ADDR_W = 24;
    localparam int IES_CNT_W = 8;
    localparam int IES_N_ERU = 4;
    localparam int IES_ERU_FIRST_NODE = 0;
    localparam int IES_N_ESR = 3;
    localparam int IES_N_HWTRAP = 8;
    localparam int IES_N_TRAP = 10;
    localparam int IES_TRAP_W = 4;
    localparam int IES_TRAP_SR0 = 8;
    localparam int IES_TRAP_SR1 = 9;
    localparam int IES_VEC_W = 8;
    localparam logic [7:0] IES_INT_VEC_BASE = 8'h10;
    localparam logic [3:0] IES_RESP_JC = 4'h7;
    localparam logic [3:0] IES_RESP_NOJC = 4'hb;
    localparam logic [23:0] IES_PTR_RESET = 24'h000000;
    localparam logic [7:0] IES_CNT_RESET = 8'h00;

    typedef struct packed {
        logic enable;
        logic [IES_PRIO_W-1:0] prio;
        logic use_pec;
        logic [IES_PEC_W-1:0] pec_chan;
    } ies_node_cfg_t;

    typedef struct packed {
        logic continuous;
        logic word;
        logic inc_src;
        logic inc_dst;
    } ies_pec_cfg_t;

    typedef struct packed {
        logic [IES_ADDR_W-1:0] src;
        logic [IES_ADDR_W-1:0] dst;
        logic [IES_CNT_W-1:0] cnt;
    } ies_pec_chan_t;

    typedef struct packed {
        logic [1:0] edge_sel;
        logic [IES_N_ERU-1:0] route;
        logic [IES_N_ERU-1:0] pattern;
        logic [1:0] gate;
    } ies_eru_cfg_t;

    localparam logic [1:0] IES_GATE_ALWAYS = 2'h0;
    localparam logic [1:0] IES_GATE_MATCH = 2'h1;
    localparam logic [1:0] IES_GATE_MISS = 2'h2;
    localparam logic [1:0] IES_GATE_NEVER = 2'h3;
endpackage

// ### ies_request_router_unit.sv
`timescale 1ns/1ps
module ies_request_router_unit import ies_pkg::*; #(
    parameter int N_CH = IES_N_ERU
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [N_CH-1:0] eru_in,
    input wire ies_eru_cfg_t eru_cfg [N_CH],
    output logic [N_CH-1:0] eru_req
);
    logic [N_CH-1:0] prev_r;
    logic [N_CH-1:0] evt;
    logic [N_CH-1:0] gated;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prev_r <= '0;
            eru_req <= '0;
        end else begin
            prev_r <= eru_in;
            eru_req <= gated;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < N_CH; i++) begin : g_ch
            // edge_trigger_logic: bit0 rising, bit1 falling, both for either edge
            assign evt[i] = (eru_cfg[i].edge_sel[0] & eru_in[i] & ~prev_r[i])
                          | (eru_cfg[i].edge_sel[1] & ~eru_in[i] & prev_r[i]);
            // output_gate_unit: routed events filtered by pattern of input levels
            wire routed = |(evt & eru_cfg[i].route);
            wire hit = (eru_in & eru_cfg[i].pattern) == eru_cfg[i].pattern;
            assign gated[i] = routed & ((eru_cfg[i].gate == IES_GATE_ALWAYS)
                            | ((eru_cfg[i].gate == IES_GATE_MATCH) & hit)
                            | ((eru_cfg[i].gate == IES_GATE_MISS) & ~hit));
        end
    endgenerate
endmodule // ies_request_router_unit

// ### ies_interrupt_system.sv
`timescale 1ns/1ps
// Overview of operation
// - each request served by vector or transfer
// - event transfer steals exactly one cycle
// - copy byte/word, bump source/destination pointers
// - decrement count unless continuous mode
// - count at zero raises standard interrupt
// - eight independent event transfer channels
// - response at least 7 or 11 clocks
// - standard service branches to node vector
// - 112 nodes with flag, enable, priority
// - shared nodes pick source via selectors
// - router: 4 channels, matrix, 4 gates
// - rising, falling or both edge detection
// - gate filters on pattern match or miss
// - trap branches to its own vector
// - each trap sets its flag bit
// - trap preempts unless equal or higher trap running
// - interrupts and transfers blocked during traps
// - three pins give two system request traps
// - software trap starts numbered vector
// - software write of request flag pends
module ies_interrupt_system import ies_pkg::*; #(
    parameter int N_NODE = IES_N_NODE,
    parameter int N_PEC = IES_N_PEC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [N_NODE-1:0] node_src_req,
    input wire logic [IES_N_SHSRC-1:0] shared_src_req,
    input wire logic [IES_SEL_W-1:0] source_select_reg [IES_N_SHARED],
    input wire ies_node_cfg_t node_cfg [N_NODE],
    input wire logic sw_req_set,
    input wire logic [IES_NODE_W-1:0] sw_req_node,
    input wire logic [IES_PRIO_W-1:0] cpu_prio,
    input wire logic jump_cache_on,
    input wire logic svc_end,
    input wire logic [IES_N_ERU-1:0] eru_in,
    input wire ies_eru_cfg_t eru_cfg [IES_N_ERU],
    input wire logic [IES_N_HWTRAP-1:0] hw_trap_in,
    input wire logic [IES_N_TRAP-1:0] trap_flag_clear,
    input wire logic [IES_N_ESR-1:0] service_request_pin,
    input wire logic [IES_N_ESR-1:0] sr0_pin_sel,
    input wire logic [IES_N_ESR-1:0] sr1_pin_sel,
    input wire logic sw_trap,
    input wire logic [IES_VEC_W-1:0] sw_trap_num,
    input wire logic pec_load,
    input wire logic [IES_PEC_W-1:0] pec_load_chan,
    input wire ies_pec_chan_t pec_load_val,
    input wire ies_pec_cfg_t pec_cfg [N_PEC],
    output logic svc_start,
    output logic [IES_VEC_W-1:0] svc_vector,
    output logic svc_is_trap,
    output logic svc_busy,
    output logic [IES_N_TRAP-1:0] trap_flag_register,
    output logic [N_NODE-1:0] request_flag_bit,
    output logic pec_steal,
    output logic [IES_ADDR_W-1:0] pec_src_addr,
    output logic [IES_ADDR_W-1:0] pec_dst_addr,
    output logic pec_word,
    output logic [IES_CNT_W-1:0] pec_count [N_PEC]
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BUSY} ies_state_t;

    ies_state_t state_r;
    logic [3:0] wait_r;
    logic [IES_NODE_W-1:0] node_r;
    logic trap_act_r;
    logic [IES_TRAP_W-1:0] trap_lvl_r;
    logic [IES_N_TRAP-1:0] trap_pend_r;
    logic [IES_N_ESR-1:0] esr_prev_r;
    ies_pec_chan_t pec_r [N_PEC];

    ////////////////////////////////////////////////////////////////////////
    // source selection and request router
    logic [IES_N_ERU-1:0] eru_req;
    logic [N_NODE-1:0] src_eff;

    ies_request_router_unit #(.N_CH(IES_N_ERU)) u_router (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .eru_in(eru_in),
        .eru_cfg(eru_cfg),
        .eru_req(eru_req)
    );

    genvar g;
    generate
        for (g = 0; g < N_NODE; g++) begin : g_src
            if (g >= IES_SHARED_FIRST && g < IES_SHARED_FIRST + IES_N_SHARED) begin : g_sh
                assign src_eff[g] =
                    shared_src_req[source_select_reg[g-IES_SHARED_FIRST]];
            end else if (g >= IES_ERU_FIRST_NODE && g < IES_ERU_FIRST_NODE + IES_N_ERU) begin : g_er
                assign src_eff[g] = node_src_req[g] | eru_req[g-IES_ERU_FIRST_NODE];
            end else begin : g_ded
                assign src_eff[g] = node_src_req[g];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // node arbitration
    logic [IES_NODE_W-1:0] win_node;
    logic [IES_PRIO_W-1:0] win_prio;
    logic win_valid;

    always_comb begin
        win_node = '0;
        win_prio = '0;
        win_valid = 1'b0;
        for (int n = 0; n < N_NODE; n++) begin
            // strict greater keeps the lowest node index on equal priority
            if (request_flag_bit[n] && node_cfg[n].enable && node_cfg[n].prio > cpu_prio
                && (!win_valid || node_cfg[n].prio > win_prio)) begin
                win_node = IES_NODE_W'(n);
                win_prio = node_cfg[n].prio;
                win_valid = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trap selection: lower index is the higher priority
    logic [IES_N_ESR-1:0] esr_rise;
    logic [IES_N_TRAP-1:0] trap_set;
    logic [IES_TRAP_W-1:0] trap_win;
    logic trap_any;
    logic trap_go;

    assign esr_rise = service_request_pin & ~esr_prev_r;
    assign trap_set = {|(esr_rise & sr1_pin_sel), |(esr_rise & sr0_pin_sel),
                       hw_trap_in};

    always_comb begin
        trap_win = '0;
        trap_any = 1'b0;
        for (int t = IES_N_TRAP - 1; t >= 0; t--) begin
            if (trap_pend_r[t]) begin
                trap_win = IES_TRAP_W'(t);
                trap_any = 1'b1;
            end
        end
    end

    assign trap_go = trap_any && (!trap_act_r || trap_win < trap_lvl_r);

    ////////////////////////////////////////////////////////////////////////
    // event transfer decision for the latched node
    ies_node_cfg_t cur_cfg;
    ies_pec_chan_t cur_pec;
    ies_pec_cfg_t cur_pcfg;
    logic wait_done;
    logic do_pec;
    logic [IES_CNT_W-1:0] cnt_dec;
    logic [IES_ADDR_W-1:0] step;
    logic [3:0] resp_load;

    assign cur_cfg = node_cfg[node_r];
    assign cur_pec = pec_r[cur_cfg.pec_chan];
    assign cur_pcfg = pec_cfg[cur_cfg.pec_chan];
    assign wait_done = (state_r == ST_WAIT) && (wait_r == 4'h0) && !trap_go;
    assign do_pec = cur_cfg.use_pec && (cur_pcfg.continuous || cur_pec.cnt != '0);
    assign cnt_dec = cur_pcfg.continuous ? cur_pec.cnt : cur_pec.cnt - 8'h01;
    assign step = cur_pcfg.word ? 24'h000002 : 24'h000001;
    // flag set, grant and flag clear take three cycles, the rest is counted here
    assign resp_load = (jump_cache_on ? IES_RESP_JC : IES_RESP_NOJC) - 4'h3;

    ////////////////////////////////////////////////////////////////////////
    // request flags: a new event wins over the clear of the same cycle
    logic [N_NODE-1:0] flag_nxt;
    logic [N_NODE-1:0] flag_clr;
    logic [N_NODE-1:0] flag_set;

    generate
        for (g = 0; g < N_NODE; g++) begin : g_flag
            assign flag_clr[g] = wait_done && node_r == IES_NODE_W'(g);
            assign flag_set[g] = src_eff[g]
                | (sw_req_set && sw_req_node == IES_NODE_W'(g))
                | (flag_clr[g] && do_pec && !cur_pcfg.continuous
                   && cnt_dec == '0);
            assign flag_nxt[g] = flag_set[g] | (request_flag_bit[g] & ~flag_clr[g]);
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            request_flag_bit <= '0;
            esr_prev_r <= '0;
        end else begin
            request_flag_bit <= flag_nxt;
            esr_prev_r <= service_request_pin;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            trap_flag_register <= '0;
            trap_pend_r <= '0;
        end else begin
            trap_flag_register <= trap_set | (trap_flag_register & ~trap_flag_clear);
            trap_pend_r <= trap_set | (trap_pend_r & ~({{(IES_N_TRAP-1){1'b0}}, trap_go}
                                                        << trap_win));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // service sequencer
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            wait_r <= '0;
            node_r <= '0;
            trap_act_r <= 1'b0;
            trap_lvl_r <= '0;
            svc_start <= 1'b0;
            svc_vector <= '0;
            svc_is_trap <= 1'b0;
            pec_steal <= 1'b0;
            pec_src_addr <= '0;
            pec_dst_addr <= '0;
            pec_word <= 1'b0;
        end else begin
            svc_start <= 1'b0;
            pec_steal <= 1'b0;
            if (trap_go) begin
                // a trap abandons any wait; its node flag stays pending
                state_r <= ST_BUSY;
                trap_act_r <= 1'b1;
                trap_lvl_r <= trap_win;
                svc_start <= 1'b1;
                svc_vector <= IES_VEC_W'(trap_win);
                svc_is_trap <= 1'b1;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        if (sw_trap) begin
                            state_r <= ST_BUSY;
                            svc_start <= 1'b1;
                            svc_vector <= sw_trap_num;
                            svc_is_trap <= 1'b0;
                        end else if (win_valid) begin
                            state_r <= ST_WAIT;
                            node_r <= win_node;
                            wait_r <= resp_load;
                        end
                    end
                    ST_WAIT: begin
                        if (wait_r != 4'h0) begin
                            wait_r <= wait_r - 4'h1;
                        end else if (do_pec) begin
                            state_r <= ST_IDLE;
                            pec_steal <= 1'b1;
                            pec_src_addr <= cur_pec.src;
                            pec_dst_addr <= cur_pec.dst;
                            pec_word <= cur_pcfg.word;
                        end else begin
                            state_r <= ST_BUSY;
                            svc_start <= 1'b1;
                            svc_vector <= IES_INT_VEC_BASE + IES_VEC_W'(node_r);
                            svc_is_trap <= 1'b0;
                        end
                    end
                    ST_BUSY: begin
                        // no return stack: a trap ends the whole service nest
                        if (svc_end) begin
                            state_r <= ST_IDLE;
                            trap_act_r <= 1'b0;
                            svc_is_trap <= 1'b0;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // idle only follows a finished trap, so no interrupt is granted inside one
    assign svc_busy = (state_r == ST_BUSY) | trap_act_r;

    ////////////////////////////////////////////////////////////////////////
    // event transfer channels
    generate
        for (g = 0; g < N_PEC; g++) begin : g_pec
            wire mine = wait_done && do_pec && cur_cfg.pec_chan == IES_PEC_W'(g);
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    pec_r[g] <= '{src: IES_PTR_RESET, dst: IES_PTR_RESET, cnt: IES_CNT_RESET};
                end else if (mine) begin
                    pec_r[g].src <= pec_r[g].src + (pec_cfg[g].inc_src ? step : '0);
                    pec_r[g].dst <= pec_r[g].dst + (pec_cfg[g].inc_dst ? step : '0);
                    pec_r[g].cnt <= cnt_dec;
                end else if (pec_load && pec_load_chan == IES_PEC_W'(g)) begin
                    pec_r[g] <= pec_load_val;
                end
            end
            assign pec_count[g] = pec_r[g].cnt;
        end
    endgenerate
endmodule // ies_interrupt_system

// ### ies_cpu_model.sv
`timescale 1ns/1ps
// stands in for the core: closes the service a set number of cycles after the latest start
module ies_cpu_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic svc_start,
    input wire logic [7:0] end_dly,
    output logic svc_end
);
    logic [7:0] cnt_r;
    // a preempting start reloads the delay, so one end closes the whole nest
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_r <= 8'h00;
            svc_end <= 1'h0;
        end else begin
            cnt_r <= svc_start ? end_dly : cnt_r - {7'h00, cnt_r != 8'h00};
            svc_end <= cnt_r == 8'h01 && !svc_start;
        end
    end
endmodule // ies_cpu_model

// ### ies_interrupt_system_sva.sv
`timescale 1ns/1ps
module ies_interrupt_system_sva import ies_pkg::*; #(
    parameter int N_NODE = IES_N_NODE
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [N_NODE-1:0] node_src_req,
    input wire logic sw_req_set,
    input wire logic [IES_NODE_W-1:0] sw_req_node,
    input wire logic [IES_N_HWTRAP-1:0] hw_trap_in,
    input wire logic svc_end,
    input wire logic svc_start,
    input wire logic [IES_VEC_W-1:0] svc_vector,
    input wire logic svc_is_trap,
    input wire logic svc_busy,
    input wire logic [IES_N_TRAP-1:0] trap_flag_register,
    input wire logic [N_NODE-1:0] request_flag_bit,
    input wire logic pec_steal
);
    logic [IES_SHARED_FIRST-1:0] ded_req;
    assign ded_req = node_src_req[IES_SHARED_FIRST-1:0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    // fresh trap on a quiet system only, so no older pending trap can take the slot
    sequence trap_taken;
        hw_trap_in != '0 && $past(hw_trap_in) == '0 && !svc_is_trap && !$past(svc_is_trap);
    endsequence
    sequence trap_begins;
        ##2 (svc_start && svc_is_trap);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    steal_one_cycle_a: assert property (pec_steal |=> !pec_steal)
        else $error("transfer steal longer than one cycle");
    trap_flag_set_a: assert property (hw_trap_in != '0 |=>
        (trap_flag_register[7:0] & $past(hw_trap_in)) == $past(hw_trap_in))
        else $error("trap flag not set");
    trap_start_a: assert property (trap_taken |-> trap_begins)
        else $error("trap service not started in two cycles");
    trap_vector_a: assert property (svc_start && svc_is_trap |->
        svc_vector < 8'h0a && trap_flag_register[svc_vector[3:0]])
        else $error("trap vector wrong");
    trap_holds_a: assert property (svc_is_trap && !svc_end |=> svc_is_trap)
        else $error("trap service dropped without end");
    trap_blocks_a: assert property (svc_is_trap && $past(svc_is_trap) |->
        svc_busy && !pec_steal)
        else $error("transfer during trap");
    req_flag_a: assert property (ded_req != '0 |=>
        (request_flag_bit[IES_SHARED_FIRST-1:0] & $past(ded_req)) == $past(ded_req))
        else $error("request flag not set");
    sw_req_a: assert property (sw_req_set |=> request_flag_bit[$past(sw_req_node)])
        else $error("software request not pending");
    start_busy_a: assert property (svc_start |-> svc_busy)
        else $error("service start without busy");
endmodule // ies_interrupt_system_sva

bind ies_interrupt_system ies_interrupt_system_sva #(.N_NODE(N_NODE)) ies_interrupt_system_sva_i (
    .clk_sys, .reset_n, .node_src_req, .sw_req_set, .sw_req_node, .hw_trap_in, .svc_end,
    .svc_start, .svc_vector, .svc_is_trap, .svc_busy, .trap_flag_register,
    .request_flag_bit, .pec_steal
);

// ### tb_ies_interrupt_system.sv
`timescale 1ns/1ps
module tb_ies_interrupt_system import ies_pkg::*;;
    logic clk_sys = 1'h0;
    logic reset_n = 1'h0;
    logic [IES_N_NODE-1:0] node_src_req = '0, request_flag_bit;
    logic [IES_N_SHSRC-1:0] shared_src_req = '0;
    logic [IES_SEL_W-1:0] source_select_reg [IES_N_SHARED] = '{default: 4'h9};
    ies_node_cfg_t node_cfg [IES_N_NODE] = '{default: '0};
    logic sw_req_set = 1'h0, jump_cache_on = 1'h1, sw_trap = 1'h0, pec_load = 1'h0, svc_end;
    logic [IES_NODE_W-1:0] sw_req_node = '0;
    logic [IES_PRIO_W-1:0] cpu_prio = '0;
    logic [IES_N_ERU-1:0] eru_in = '0;
    ies_eru_cfg_t eru_cfg [IES_N_ERU] = '{{2'h1, 4'h1, 4'h0, IES_GATE_ALWAYS},
        {2'h2, 4'h2, 4'h0, IES_GATE_ALWAYS}, {2'h3, 4'h4, 4'h8, IES_GATE_MATCH},
        {2'h0, 4'h4, 4'h8, IES_GATE_MISS}};
    logic [IES_N_HWTRAP-1:0] hw_trap_in = '0;
    logic [IES_N_TRAP-1:0] trap_flag_clear = '0, trap_flag_register;
    logic [IES_N_ESR-1:0] service_request_pin = '0, sr0_pin_sel = 3'h2, sr1_pin_sel = 3'h4;
    logic [IES_VEC_W-1:0] sw_trap_num = '0, svc_vector;
    logic [IES_PEC_W-1:0] pec_load_chan = '0;
    ies_pec_chan_t pec_load_val = '0;
    ies_pec_cfg_t pec_cfg [IES_N_PEC] = '{default: '0};
    ies_pec_cfg_t cfg;
    logic svc_start, svc_is_trap, svc_busy, pec_steal, pec_word;
    logic [IES_ADDR_W-1:0] pec_src_addr, pec_dst_addr, src, dst;
    logic [IES_CNT_W-1:0] pec_count [IES_N_PEC];
    logic [IES_CNT_W-1:0] cnt;
    logic [7:0] end_dly = 8'h02;
    logic [16:0] seed = 17'h1365e;
    int n_errors = 0, checks = 0, n_start = 0, n, k, tot;

    ies_interrupt_system ies_interrupt_system_i (.clk_sys, .reset_n, .node_src_req,
        .shared_src_req, .source_select_reg, .node_cfg, .sw_req_set, .sw_req_node, .cpu_prio,
        .jump_cache_on, .svc_end, .eru_in, .eru_cfg, .hw_trap_in, .trap_flag_clear,
        .service_request_pin, .sr0_pin_sel, .sr1_pin_sel, .sw_trap, .sw_trap_num, .pec_load,
        .pec_load_chan, .pec_load_val, .pec_cfg, .svc_start, .svc_vector, .svc_is_trap,
        .svc_busy, .trap_flag_register, .request_flag_bit, .pec_steal, .pec_src_addr,
        .pec_dst_addr, .pec_word, .pec_count);
    ies_cpu_model ies_cpu_model_i (.clk_sys, .reset_n, .svc_start, .end_dly, .svc_end);

    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (svc_start === 1'h1) n_start++;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    function automatic logic [23:0] bump(input logic [23:0] p, input logic inc, input logic w);
        return p + (inc ? (w ? 24'h2 : 24'h1) : 24'h0);
    endfunction
    function automatic logic seen(input int w);
        return w == 0 ? svc_start : w == 1 ? pec_steal : !svc_busy;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // 0 start, 1 steal, 2 idle; n counts cycles from the last drive edge
    task automatic wait_on(input int w);
        n = 1;
        #1;
        while (seen(w) !== 1'h1 && n < 300) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 300) begin
            chk(32'h0, 32'h1);
            stop_test();
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'h1;
        #1;
        chk({svc_busy, svc_start, pec_steal, |request_flag_bit, |trap_flag_register}, 0);
        @(posedge clk_sys);
        eru_in <= 4'h7;
        shared_src_req <= 16'h0200;
        @(posedge clk_sys);
        shared_src_req <= '0;
        repeat (5) @(posedge clk_sys);
        #1;
        chk(request_flag_bit[3:0], 4'h9);
        chk(request_flag_bit[IES_SHARED_FIRST], 1'h1);
        @(posedge clk_sys);
        eru_in <= 4'h5;
        repeat (5) @(posedge clk_sys);
        #1;
        chk(request_flag_bit[3:0], 4'hb);
        $display("router test done");
        for (int jc = 0; jc < 2; jc++) begin
            @(posedge clk_sys);
            node_cfg[5] <= {1'h1, 4'h3, 1'h0, 3'h0};
            jump_cache_on <= jc[0];
            node_src_req[5] <= 1'h1;
            @(posedge clk_sys);
            node_src_req[5] <= 1'h0;
            wait_on(0);
            chk(n, jc ? 7 : 11);
            chk(svc_vector, IES_INT_VEC_BASE + 8'h05);
            wait_on(2);
        end
        $display("latency test done");
        @(posedge clk_sys);
        cpu_prio <= 4'h5;
        node_cfg[20] <= {1'h1, 4'h2, 4'h0};
        node_cfg[30] <= {1'h1, 4'h5, 4'h0};
        sw_req_set <= 1'h1;
        sw_req_node <= 7'h14;
        node_src_req[30] <= 1'h1;
        @(posedge clk_sys);
        sw_req_set <= 1'h0;
        node_src_req[30] <= 1'h0;
        k = n_start;
        repeat (15) @(posedge clk_sys);
        #1;
        chk(n_start, k);
        @(posedge clk_sys);
        cpu_prio <= 4'h1;
        wait_on(0);
        chk(svc_vector, 8'h2e);
        wait_on(2);
        wait_on(0);
        chk(svc_vector, 8'h24);
        wait_on(2);
        $display("priority test done");
        for (int ch = 0; ch < IES_N_PEC; ch++) begin
            seed = lfsr(seed);
            src = {seed[6:0], seed};
            seed = lfsr(seed);
            dst = {seed, seed[6:0]};
            cfg = seed[3:0];
            cnt = {6'h00, seed[5:4]} + 8'h01;
            tot = cfg.continuous ? 2 : int'(cnt);
            @(posedge clk_sys);
            pec_cfg[ch] <= cfg;
            node_cfg[40 + ch] <= {1'h1, 4'h2, 1'h1, ch[2:0]};
            pec_load <= 1'h1;
            pec_load_chan <= ch[2:0];
            pec_load_val <= {src, dst, cnt};
            @(posedge clk_sys);
            pec_load <= 1'h0;
            for (int t = 0; t < tot; t++) begin
                @(posedge clk_sys);
                node_src_req[40 + ch] <= 1'h1;
                @(posedge clk_sys);
                node_src_req[40 + ch] <= 1'h0;
                wait_on(1);
                chk(n, 7);
                chk({pec_word, pec_src_addr}, {cfg.word, src});
                chk(pec_dst_addr, dst);
                src = bump(src, cfg.inc_src, cfg.word);
                dst = bump(dst, cfg.inc_dst, cfg.word);
                cnt = cfg.continuous ? cnt : cnt - 8'h01;
                @(posedge clk_sys);
                #1;
                chk(pec_count[ch], cnt);
            end
            if (!cfg.continuous) begin
                wait_on(0);
                chk(svc_vector, 8'h38 + ch[7:0]);
                wait_on(2);
            end
        end
        $display("transfer test done");
        for (int t = 0; t < IES_N_TRAP; t++) begin
            @(posedge clk_sys);
            if (t < 8) hw_trap_in <= 8'h01 << t;
            // pins move only on the clock edge; one assignment per edge
            service_request_pin <= (t < 8) ? 3'h0 : 3'(3'h1 << (t - 7));
            @(posedge clk_sys);
            hw_trap_in <= '0;
            wait_on(0);
            chk(n, 2);
            chk({svc_is_trap, svc_vector}, {1'h1, t[7:0]});
            chk(trap_flag_register[t], 1'h1);
            wait_on(2);
        end
        @(posedge clk_sys);
        service_request_pin <= '0;
        trap_flag_clear <= '1;
        end_dly <= 8'h28;
        @(posedge clk_sys);
        trap_flag_clear <= '0;
        hw_trap_in <= 8'h20;
        #1;
        chk(trap_flag_register, 0);
        @(posedge clk_sys);
        hw_trap_in <= 8'h40;
        @(posedge clk_sys);
        hw_trap_in <= 8'h00;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(svc_vector, 8'h05);
        @(posedge clk_sys);
        hw_trap_in <= 8'h04;
        node_src_req[5] <= 1'h1;
        @(posedge clk_sys);
        hw_trap_in <= 8'h00;
        node_src_req[5] <= 1'h0;
        wait_on(0);
        chk({n[7:0], svc_vector}, 16'h0202);
        @(posedge clk_sys);
        wait_on(0);
        chk(svc_vector, 8'h06);
        @(posedge clk_sys);
        wait_on(0);
        chk(svc_vector, 8'h15);
        wait_on(2);
        $display("trap test done");
        seed = lfsr(seed);
        @(posedge clk_sys);
        sw_trap <= 1'h1;
        sw_trap_num <= seed[7:0];
        @(posedge clk_sys);
        sw_trap <= 1'h0;
        wait_on(0);
        chk({n[7:0], svc_vector}, {8'h01, seed[7:0]});
        wait_on(2);
        $display("software trap test done");
        stop_test();
    end
endmodule // tb_ies_interrupt_system
